// *** design/iep_pkg.sv ***
// Package for the interrupt enable and priority register slice.
// Assumes a 32-bit APB master and one 100 MHz clock domain.
package iep_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] IEP_OFF_WAKE_EN  = 8'h00;
  localparam logic [7:0] IEP_OFF_CELL_EN  = 8'h04;
  localparam logic [7:0] IEP_OFF_PRIO0    = 8'h08;
  localparam int         IEP_ADDR_W       = 8;
  localparam int         IEP_REG_W        = 16;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         IEP_WAKE_BIT     = 0;
  localparam int         IEP_CELL1_BIT    = 0;
  localparam int         IEP_CELL2_BIT    = 1;
  localparam int         IEP_PRIO_W       = 3;
  localparam int         IEP_PRIO_N       = 4;
  localparam int         IEP_PRIO_STRIDE  = 4;
  localparam logic [2:0] IEP_PRIO_RST     = 3'h4;
  localparam logic [15:0] IEP_WAKE_MASK   = 16'h0001;
  localparam logic [15:0] IEP_CELL_MASK   = 16'h0003;
  localparam logic [15:0] IEP_PRIO_MASK   = 16'h7777;

  // Priority fields, field 0 is external interrupt 0 in the low bits.
  typedef struct packed {
    logic [2:0] timer_one_priority;
    logic [2:0] capcomp_two_priority;
    logic [2:0] capcomp_one_priority;
    logic [2:0] ext_irq_zero_priority;
  } iep_prio_t;

  // Raw interrupt requests entering the gate.
  typedef struct packed {
    logic low_power_wake;
    logic logic_cell_two;
    logic logic_cell_one;
  } iep_req_t;

endpackage : iep_pkg

// *** design/iep_prio_field.sv ***
// One 3-bit priority field held in flip-flops.
// Assumes the caller supplies a one-cycle write strobe.
module iep_prio_field
  import iep_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Write port
  input  wire logic       i_we,
  input  wire logic [2:0] i_wdata,
  // Stored value
  output logic      [2:0] o_value
);

  logic [2:0] value_r;
  logic [2:0] value_nxt;

  // Next value follows the write strobe.
  always_comb
  begin
    value_nxt = i_we ? i_wdata : value_r;
  end

  // Field comes out of reset with only its top bit set.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      value_r <= IEP_PRIO_RST; // RULE7
    else
      value_r <= value_nxt;
  end

  assign o_value = value_r;

endmodule // iep_prio_field

// *** design/iep_regs.sv ***
// APB register slice: two interrupt enable registers and priority bank zero.
// Assumes an APB master on i_clk; registers answer with no wait states.
// Operation
// (RULE1) Wake enable bit 0 gates the low-power wake request; resets to 0.
// (RULE2) Wake enable bits 15 to 1 read as zero.
// (RULE3) Logic cell enable bit 1 gates cell two request; resets to 0.
// (RULE4) Logic cell enable bit 0 gates cell one request; resets to 0.
// (RULE5) Logic cell enable bits 15 to 2 read as zero.
// (RULE6) Priority bank zero holds four 3-bit fields; bits 15,11,7,3 read zero.
// (RULE7) Every priority field resets to binary 100.
// (RULE8) Writes to unimplemented bits are dropped and change nothing.
//
// Chosen here: the address map and the APB interface to the registers.
module iep_regs
  import iep_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  // APB slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [IEP_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]           i_pwdata,
  input  wire logic [3:0]            i_pstrb,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // Interrupt requests and gated results
  input  wire iep_req_t              i_req,
  output iep_req_t                   o_req_gated,
  output iep_prio_t                  o_prio
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Decoding is used by both the write and read paths.
  function automatic logic [2:0] iep_decode(input logic [IEP_ADDR_W-1:0] a);
    iep_decode = {a == IEP_OFF_PRIO0, a == IEP_OFF_CELL_EN, a == IEP_OFF_WAKE_EN};
  endfunction

  logic [2:0]  sel;
  logic        wr_acc;
  logic        rd_acc;
  logic [15:0] wdata16;
  logic        lane_lo;
  logic        lane_hi;

  // Writes act only in the access phase; lane strobes gate each byte.
  always_comb
  begin
    sel     = iep_decode(i_paddr);
    wr_acc  = i_psel && i_penable && i_pwrite;
    rd_acc  = i_psel && !i_pwrite;
    lane_lo = i_pstrb[0];
    lane_hi = i_pstrb[1];
    wdata16 = i_pwdata[15:0];
  end

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------
  logic [15:0] wake_irq_enable_r;
  logic [15:0] wake_irq_enable_nxt;
  logic [15:0] logic_cell_irq_enable_r;
  logic [15:0] logic_cell_irq_enable_nxt;

  // Only implemented bits are stored, so stray writes cannot stick.
  always_comb
  begin
    wake_irq_enable_nxt       = wake_irq_enable_r;
    logic_cell_irq_enable_nxt = logic_cell_irq_enable_r;
    if (wr_acc && sel[0] && lane_lo)
      wake_irq_enable_nxt = wdata16 & IEP_WAKE_MASK; // RULE8
    if (wr_acc && sel[1] && lane_lo)
      logic_cell_irq_enable_nxt = wdata16 & IEP_CELL_MASK; // RULE8
  end

  // Enables come out of reset blocked.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wake_irq_enable_r       <= 16'h0000; // RULE1
      logic_cell_irq_enable_r <= 16'h0000; // RULE3
    end
    else
    begin
      wake_irq_enable_r       <= wake_irq_enable_nxt;
      logic_cell_irq_enable_r <= logic_cell_irq_enable_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Priority fields
  // ----------------------------------------------------------------
  logic [IEP_PRIO_N*IEP_PRIO_W-1:0] prio_flat;

  // Each field needs its lane; fields 0,1 sit in byte 0 and 2,3 in byte 1.
  genvar g;
  generate
    for (g = 0; g < IEP_PRIO_N; g++)
    begin : g_prio
      logic we;
      assign we = wr_acc && sel[2] && ((g < 2) ? lane_lo : lane_hi);
      iep_prio_field u_field
      (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_we    (we),
        .i_wdata (wdata16[g*IEP_PRIO_STRIDE +: IEP_PRIO_W]), // RULE6
        .o_value (prio_flat[g*IEP_PRIO_W +: IEP_PRIO_W])
      );
    end
  endgenerate

  assign o_prio = prio_flat;

  // Packed priority image with the gap bits at zero.
  logic [15:0] prio_image;
  always_comb
  begin
    prio_image = {1'b0, o_prio.timer_one_priority,
                  1'b0, o_prio.capcomp_two_priority,
                  1'b0, o_prio.capcomp_one_priority,
                  1'b0, o_prio.ext_irq_zero_priority}; // RULE6
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // Read data is registered in the setup cycle so it is stable in access.
  always_comb
  begin
    prdata_nxt = prdata_r;
    if (rd_acc && !i_penable)
    begin
      case (sel)
        3'h1:    prdata_nxt = {16'h0000, wake_irq_enable_r & IEP_WAKE_MASK}; // RULE2
        3'h2:    prdata_nxt = {16'h0000, logic_cell_irq_enable_r & IEP_CELL_MASK}; // RULE5
        3'h4:    prdata_nxt = {16'h0000, prio_image & IEP_PRIO_MASK};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      prdata_r <= 32'h0000_0000;
    else
      prdata_r <= prdata_nxt;
  end

  assign o_prdata  = prdata_r;
  assign o_pready  = 1'b1;
  // Unmapped addresses answer with an error and change nothing.
  assign o_pslverr = i_psel && i_penable && (sel == 3'h0);

  // ----------------------------------------------------------------
  // Request gating
  // ----------------------------------------------------------------
  // Gating is a plain AND so a request is seen the cycle its enable is set.
  always_comb
  begin
    o_req_gated.low_power_wake =
      i_req.low_power_wake & wake_irq_enable_r[IEP_WAKE_BIT]; // RULE1
    o_req_gated.logic_cell_two =
      i_req.logic_cell_two & logic_cell_irq_enable_r[IEP_CELL2_BIT]; // RULE3
    o_req_gated.logic_cell_one =
      i_req.logic_cell_one & logic_cell_irq_enable_r[IEP_CELL1_BIT]; // RULE4
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // Stored bits and read images are both checked, since either could leak a gap bit.
  wake_gate_a: assert property ( // RULE1
    o_req_gated.low_power_wake == (i_req.low_power_wake && wake_irq_enable_r[0]))
    else $error("wake gate wrong");
  wake_write_a: assert property ( // RULE1
    wr_acc && sel[0] && lane_lo |=> wake_irq_enable_r[0] == $past(i_pwdata[0]))
    else $error("wake enable lost");
  wake_unused_a: assert property ( // RULE2
    wake_irq_enable_r[15:1] == 15'h0)
    else $error("wake unused bits set");
  wake_read_a: assert property ( // RULE2
    rd_acc && !i_penable && sel == 3'h1 |=> o_prdata[31:1] == 31'h0)
    else $error("wake unused bits read");
  cell_two_a: assert property ( // RULE3
    wr_acc && sel[1] && lane_lo |=> logic_cell_irq_enable_r[1] == $past(i_pwdata[1]))
    else $error("cell two lost");
  cell_one_a: assert property ( // RULE4
    wr_acc && sel[1] && lane_lo |=> logic_cell_irq_enable_r[0] == $past(i_pwdata[0]))
    else $error("cell one lost");
  cell_unused_a: assert property ( // RULE5
    logic_cell_irq_enable_r[15:2] == 14'h0)
    else $error("cell unused bits set");
  cell_read_a: assert property ( // RULE5
    rd_acc && !i_penable && sel == 3'h2 |=> o_prdata[31:2] == 30'h0)
    else $error("cell unused bits read");
  prio_read_a: assert property ( // RULE6
    rd_acc && !i_penable && sel == 3'h4 |=> (o_prdata & 32'hffff_8888) == 32'h0)
    else $error("prio gap bits read");
  prio_write_a: assert property ( // RULE6
    wr_acc && sel[2] && lane_hi |=> o_prio.timer_one_priority == $past(i_pwdata[14:12]))
    else $error("timer priority lost");
  prio_hold_a: assert property ( // RULE6
    !(wr_acc && sel[2]) |=> $stable(o_prio))
    else $error("prio changed without write");
  prio_rst_a: assert property ( // RULE7
    $rose(i_rst_b) |-> o_prio == 12'h924)
    else $error("prio reset value wrong");
  unused_write_a: assert property ( // RULE8
    wr_acc && sel[0] |=> wake_irq_enable_r[15:1] == 15'h0)
    else $error("unused write stuck");
  // An unmapped write must leave every stored setting untouched.
  bad_write_a: assert property ( // RULE8
    wr_acc && sel == 3'h0 |=> $stable(wake_irq_enable_r) && $stable(logic_cell_irq_enable_r)
      && $stable(o_prio))
    else $error("unmapped write changed state");

  wake_pass_c: cover property (o_req_gated.low_power_wake);
  cell_pass_c: cover property (o_req_gated.logic_cell_two && o_req_gated.logic_cell_one);
  prio_wr_c:   cover property (wr_acc && sel[2] ##1 o_prio != 12'h924);
  bad_addr_c:  cover property (o_pslverr);

endmodule // iep_regs

// *** testbench/tb_top.sv ***
// Self-checking bench for the interrupt enable and priority register slice.
// Assumes iep_pkg is compiled first; the bench is the only APB master.
module tb_top
  import iep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic        i_clk, i_rst_b, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [3:0]  i_pstrb;
  logic        o_pready, o_pslverr;
  iep_req_t    i_req, o_req_gated;
  iep_prio_t   o_prio;
  logic [32:0] exp_q[$];
  logic        err_q[$];
  logic [15:0] mdl[3];
  int          n_fail, check_count;
  integer      seed;

  iep_regs DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_req(i_req),
    .o_req_gated(o_req_gated), .o_prio(o_prio));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer; the wait for pready is bounded so a hang ends the run.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= d;
    i_pstrb   <= s;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (o_pready !== 1'b1)
    begin
      n_fail++;
      conclude();
    end
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // Reads note {error, data} first; the monitor below does the comparing.
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  // Writes note the expected error response for the monitor.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic e);
    err_q.push_back(e);
    apb(1'b1, a, d, s);
  endtask

  // Drive random requests and compare the gated result and priority outputs.
  task automatic outs();
    iep_req_t r;
    r = iep_req_t'(3'($random(seed)));
    @(posedge i_clk);
    i_req <= r;
    @(negedge i_clk);
    chk("gated", 33'(o_req_gated), 33'(r & {mdl[0][0], mdl[1][1], mdl[1][0]}));
    chk("prio", 33'(o_prio), 33'({mdl[2][14:12], mdl[2][10:8], mdl[2][6:4], mdl[2][2:0]}));
  endtask

  // Monitor: every completed read takes the oldest expectation.
  always @(posedge i_clk)
  begin
    if (i_psel && i_penable && o_pready && !i_pwrite && exp_q.size() > 0)
      chk("read", {o_pslverr, o_prdata}, exp_q.pop_front());
    if (i_psel && i_penable && o_pready && i_pwrite && err_q.size() > 0)
      chk("write error", 33'(o_pslverr), 33'(err_q.pop_front()));
  end
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Two passes so the second starts from a reset taken in mid-run.
  initial
  begin
    logic [31:0] w;
    logic [15:0] m;
    logic [3:0]  s;
    int          j;
    seed = 32'h39bebd5c;
    {i_rst_b, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb, i_req} = '0;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (16) @(posedge i_clk);
      i_rst_b <= 1'b1;
      mdl = '{16'h0000, 16'h0000, 16'h4444};
      rd(IEP_OFF_WAKE_EN, 33'h0);
      rd(IEP_OFF_CELL_EN, 33'h0);
      rd(IEP_OFF_PRIO0, 33'h4444);
      outs();
      for (int i = 0; i < 24; i++)
      begin
        j = $unsigned($random(seed)) % 3;
        w = (i == 0) ? 32'hffffffff : $random(seed);
        s = (i < 3) ? 4'hf : 4'($random(seed));
        m = (j == 0) ? IEP_WAKE_MASK : (j == 1) ? IEP_CELL_MASK : IEP_PRIO_MASK;
        wr(8'(j * 4), w, s, 1'b0);
        for (int b = 0; b < 2; b++)
          if (s[b])
            mdl[j][8*b+:8] = w[8*b+:8] & m[8*b+:8];
        rd(8'(j * 4), {17'h0, mdl[j]});
        outs();
      end
      // An unmapped word must refuse and leave every register as it was.
      wr(8'h0c, 32'hffffffff, 4'hf, 1'b1);
      rd(8'h0c, {1'b1, 32'h0});
      rd(IEP_OFF_PRIO0, {17'h0, mdl[2]});
      outs();
    end
    repeat (2) @(posedge i_clk);
    chk("pending", 33'(exp_q.size()), 33'h0);
    chk("pending writes", 33'(err_q.size()), 33'h0);
    conclude();
  end
endmodule // tb_top
